// ===== rtl/sbi_bus_if.sv
`timescale 1ns/1ns
module sbi_bus_if
   import sbi_pkg::*;
#(
   parameter sbi_variant_t VARIANT = SBI_FULL
) (
   input wire logic clk_in, // 50 MHz system clock
   input wire logic rstn_in, // async reset, active low
   input wire sbi_req_t req_in, // core request for the next bus cycle
   output logic req_take_out, // pulse: req_in taken this edge
   output logic [DATA_W-1:0] rd_data_out, // last read byte
   output logic rd_valid_out, // pulse: rd_data_out fresh
   output logic phi1_out, // first clock phase
   output logic phi2_out, // second clock phase
   output logic [ADDR_W-1:0] addr_out, // address lines
   output logic rw_out, // high read, low write
   output logic sync_out, // opcode-fetch marker
   input wire logic [DATA_W-1:0] data_in, // data pins, input side
   output logic [DATA_W-1:0] data_out, // data pins, output side
   output logic data_oen_out, // data pin enable, low drives
   input wire logic data_bus_drive_enable_in, // external gate on data drive
   input wire logic rdy_in, // ready, low stalls reads
   input wire logic irqn_in, // maskable request, active low
   input wire logic nmin_in, // non-maskable request, active low
   output logic irq_out, // maskable request level to core
   output logic nmi_pend_out, // latched non-maskable edge
   input wire logic nmi_ack_in // core clears nmi_pend_out
);

   // =====================================================================
   // variant decoding
   function automatic logic [ADDR_W-1:0] addr_mask(input sbi_variant_t v);
      case (v)
         SBI_FULL: addr_mask = '1;
         SBI_A13_IRQ: addr_mask = ADDR_W'((17'h1 << ADDR_W_A13) - 17'h1);
         default: addr_mask = ADDR_W'((17'h1 << ADDR_W_A12) - 17'h1);
      endcase
   endfunction : addr_mask

   localparam logic HAS_NMI = (VARIANT == SBI_FULL) || (VARIANT == SBI_A12_NMI);
   localparam logic HAS_RDY = (VARIANT == SBI_FULL) || (VARIANT == SBI_A12_RDY);
   localparam logic [ADDR_W-1:0] AMASK = addr_mask(VARIANT);
   localparam int GAP_DLY = GAP_CYC + 1;

   // =====================================================================
   // phase sequencer
   sbi_state_t state;
   sbi_state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic last;

   always_comb begin
      next_state = state;
      next_cnt = cnt + CNT_W'(1);
      case (state)
         SBI_PH1, SBI_PH2: last = (cnt == PHI_LAST);
         default: last = (cnt == GAP_LAST);
      endcase
      if (last) begin
         next_cnt = CNT_RST;
         case (state)
            SBI_PH1: next_state = SBI_GAP1;
            SBI_GAP1: next_state = SBI_PH2;
            SBI_PH2: next_state = SBI_GAP2;
            SBI_GAP2: next_state = SBI_PH1;
            default: next_state = SBI_GAP2;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= SBI_GAP2;
         cnt <= CNT_RST;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // non-overlap holds because both come from one state register
   assign phi1_out = (state == SBI_PH1);
   assign phi2_out = (state == SBI_PH2);

   // =====================================================================
   // bus cycle registers
   logic stall;
   logic next_stall;
   logic stall_now;
   logic [ADDR_W-1:0] next_addr;
   logic next_rw;
   logic next_sync;
   logic [DATA_W-1:0] next_wdata;
   logic [DATA_W-1:0] next_rd_data;
   logic next_rd_valid;

   // ready is honoured on reads only; a write always completes
   assign stall_now = phi2_out && last && rw_out && HAS_RDY && !rdy_in;
   // a new request every bus cycle unless a read is being held
   assign req_take_out = (state == SBI_GAP2) && last && !stall;

   always_comb begin
      next_addr = addr_out;
      next_rw = rw_out;
      next_sync = sync_out;
      next_wdata = data_out;
      next_rd_data = rd_data_out;
      next_rd_valid = 1'b0;
      next_stall = stall;
      if (req_take_out) begin
         // changes land on the first edge of the first phase
         next_addr = req_in.addr & AMASK;
         next_rw = !req_in.write;
         next_sync = req_in.fetch && !req_in.write;
         next_wdata = req_in.wdata;
      end
      if (phi2_out && last) begin
         next_stall = stall_now;
         if (rw_out) begin
            next_rd_data = data_in;
            next_rd_valid = !stall_now;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         addr_out <= ADDR_RST;
         rw_out <= 1'b1;
         sync_out <= 1'b0;
         data_out <= DATA_RST;
         rd_data_out <= DATA_RST;
         rd_valid_out <= 1'b0;
         stall <= 1'b0;
      end else begin
         addr_out <= next_addr;
         rw_out <= next_rw;
         sync_out <= next_sync;
         data_out <= next_wdata;
         rd_data_out <= next_rd_data;
         rd_valid_out <= next_rd_valid;
         stall <= next_stall;
      end
   end

   // drive only in the second phase of a write, and only while gated open
   assign data_oen_out = !(!rw_out && phi2_out && data_bus_drive_enable_in);

   // =====================================================================
   // interrupt inputs
   logic irqn_q;
   logic nmin_q;
   logic nmi_pend;
   logic next_nmi_pend;

   always_comb begin
      next_nmi_pend = nmi_pend;
      if (nmi_ack_in) begin
         next_nmi_pend = 1'b0;
      end
      // an edge in the ack cycle is kept
      if (HAS_NMI && nmin_q && !nmin_in) begin
         next_nmi_pend = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irqn_q <= 1'b1;
         nmin_q <= 1'b1;
         nmi_pend <= 1'b0;
      end else begin
         irqn_q <= irqn_in;
         nmin_q <= nmin_in;
         nmi_pend <= next_nmi_pend;
      end
   end

   // level request; the wired-OR line stays low until a source is served
   assign irq_out = !irqn_q;
   assign nmi_pend_out = nmi_pend;

   // =====================================================================
   // checker helpers: cycle counts kept apart from the sequencer counter
   localparam int BUS_CYC = 2 * (PHI_CYC + GAP_CYC);
   logic slot;
   logic slot_seen;
   logic next_slot_seen;
   logic [7:0] slot_cnt;
   logic [7:0] next_slot_cnt;
   logic [CNT_W-1:0] hi_len;
   logic [CNT_W-1:0] next_hi_len;

   // slot where a take is due, whether or not a held read skips it
   assign slot = (state == SBI_GAP2) && last;

   always_comb begin
      next_slot_seen = slot_seen || slot;
      next_slot_cnt = slot ? 8'h00 : slot_cnt + 8'h01;
      next_hi_len = (phi1_out || phi2_out) ? hi_len + CNT_W'(1) : CNT_RST;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         slot_seen <= 1'b0;
         slot_cnt <= 8'h00;
         hi_len <= CNT_RST;
      end else begin
         slot_seen <= next_slot_seen;
         slot_cnt <= next_slot_cnt;
         hi_len <= next_hi_len;
      end
   end

   // =====================================================================
   // checks
   chk_addr_phase1: assert property (@(posedge clk_in) disable iff (!rstn_in)
      $changed(addr_out) |-> phi1_out)
      else $error("address moved outside first phase");

   chk_rw_phase1: assert property (@(posedge clk_in) disable iff (!rstn_in)
      $changed(rw_out) |-> phi1_out && $past(req_take_out))
      else $error("direction moved outside first phase");

   chk_phase_overlap: assert property (@(posedge clk_in) disable iff (!rstn_in)
      $fell(phi1_out) |-> !phi2_out [*3] ##1 phi2_out)
      else $error("phases overlap or gap wrong");

   chk_drive_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !data_oen_out |-> !rw_out && phi2_out)
      else $error("data driven outside a write phase");

   chk_read_release: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rw_out |-> data_oen_out)
      else $error("data driven during a read");

   chk_addr_width: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (addr_out & ~AMASK) == '0)
      else $error("address beyond variant width");

   chk_stall_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
      stall_now |=> !rd_valid_out ##GAP_DLY phi1_out && $stable(addr_out) && rw_out)
      else $error("stalled read lost its address");

   chk_read_data: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_valid_out |-> $past(phi2_out) && rw_out && rd_data_out == $past(data_in))
      else $error("read data not taken in second phase");

   chk_take_cycle: assert property (@(posedge clk_in) disable iff (!rstn_in)
      $rose(phi1_out) |-> $past(req_take_out) || stall)
      else $error("bus cycle without a transfer");

   chk_nmi_latch: assert property (@(posedge clk_in) disable iff (!rstn_in)
      HAS_NMI && nmin_q && !nmin_in |=> nmi_pend_out)
      else $error("non-maskable edge lost");

   chk_fetch_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
      sync_out |-> rw_out)
      else $error("fetch marker on a write");

   chk_phase_width: assert property (@(posedge clk_in) disable iff (!rstn_in)
      ($fell(phi1_out) || $fell(phi2_out)) |-> hi_len == CNT_W'(PHI_CYC))
      else $error("clock phase width wrong");

   chk_slot_spacing: assert property (@(posedge clk_in) disable iff (!rstn_in)
      slot && slot_seen |-> slot_cnt == 8'(BUS_CYC - 1))
      else $error("bus cycle length wrong");

   chk_write_nostall: assert property (@(posedge clk_in) disable iff (!rstn_in)
      $fell(phi2_out) && !rw_out |-> ##2 req_take_out)
      else $error("write held by ready");

   chk_read_retry: assert property (@(posedge clk_in) disable iff (!rstn_in)
      $fell(phi2_out) && rw_out && !rd_valid_out |-> ##2 !req_take_out && stall)
      else $error("held read not repeated");

   chk_gate_off: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !data_bus_drive_enable_in |-> data_oen_out)
      else $error("data driven with gate closed");

   chk_irq_follow: assert property (@(posedge clk_in) disable iff (!rstn_in)
      $past(rstn_in) |-> irq_out == !$past(irqn_in))
      else $error("maskable request level lost");

endmodule : sbi_bus_if

// ===== rtl/sbi_pkg.sv
package sbi_pkg;

   // =====================================================================
   // bus widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int ADDR_W_A13 = 13;
   localparam int ADDR_W_A12 = 12;
   localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   // =====================================================================
   // phase timing, 1 MHz bus cycle from a 50 MHz clock
   localparam int CLK_NS = 20;
   localparam int PHI_HIGH_NS = 440;
   localparam int PHI_GAP_NS = 60;
   // least times: round up
   localparam int PHI_CYC = (PHI_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_CYC = (PHI_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = $clog2(PHI_CYC + 1);
   localparam logic [CNT_W-1:0] PHI_LAST = CNT_W'(PHI_CYC - 1);
   localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_RST = '0;

   // =====================================================================
   // pin-count variants and bus sequencer states
   typedef enum {SBI_FULL, SBI_A13_IRQ, SBI_A12_NMI, SBI_A12_RDY} sbi_variant_t;
   typedef enum {SBI_PH1, SBI_GAP1, SBI_PH2, SBI_GAP2} sbi_state_t;

   // one core request per bus cycle
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic write;
      logic [DATA_W-1:0] wdata;
      logic fetch;
   } sbi_req_t;

endpackage : sbi_pkg

// ===== testbench/sbi_bus_if_tb.sv
`timescale 1ns/1ns
module sbi_bus_if_tb
   import sbi_pkg::*;
;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   sbi_req_t req_in;
   sbi_req_t cur;
   logic req_take_out, rd_valid_out, phi1_out, phi2_out, rw_out, sync_out;
   logic data_oen_out, irq_out, nmi_pend_out, g;
   logic [DATA_W-1:0] rd_data_out, data_in, data_out;
   logic [ADDR_W-1:0] addr_out;
   logic prev_phi1 = 1'b0;
   logic prev_phi2 = 1'b0;
   logic prev_irqn = 1'b1;
   logic prev_rst = 1'b0;
   logic gate = 1'b1;
   logic rdy_in = 1'b1;
   logic irqn_in = 1'b1;
   logic nmin_in = 1'b1;
   logic nmi_ack_in = 1'b0;
   logic [DATA_W-1:0] expm [logic [ADDR_W-1:0]];
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   int takes = 0;
   int last_take = 0;
   int stalls = 0;
   logic [1:0] irq_src = 2'b00;
   localparam int BUS_CYC = 2 * (PHI_CYC + GAP_CYC);

   always #10 clk_in = ~clk_in;

   sbi_bus_if dut (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req_in),
      .req_take_out(req_take_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
      .phi1_out(phi1_out), .phi2_out(phi2_out), .addr_out(addr_out), .rw_out(rw_out),
      .sync_out(sync_out), .data_in(data_in), .data_out(data_out),
      .data_oen_out(data_oen_out), .data_bus_drive_enable_in(gate), .rdy_in(rdy_in),
      .irqn_in(irqn_in), .nmin_in(nmin_in), .irq_out(irq_out),
      .nmi_pend_out(nmi_pend_out), .nmi_ack_in(nmi_ack_in));

   sbi_mem_model mem (.clk_in(clk_in), .phi2_in(phi2_out), .addr_in(addr_out),
      .rw_in(rw_out), .wr_in(data_out), .oen_in(data_oen_out), .rd_out(data_in));

   // =====================================================================
   // expectations and reporting
   function automatic logic [DATA_W-1:0] exp_rd(input logic [ADDR_W-1:0] a);
      return expm.exists(a) ? expm[a] : (a[7:0] ^ a[15:8]);
   endfunction : exp_rd

   // addresses bunch at both ends so writes get read back
   function automatic sbi_req_t rnd_req();
      sbi_req_t r;
      r.addr = 16'(($urandom % 2) ? (16'hfff0 | ($urandom % 16)) : ($urandom % 16));
      r.write = 1'($urandom % 3 == 0);
      r.wdata = 8'($urandom);
      r.fetch = 1'($urandom % 2);
      return r;
   endfunction : rnd_req

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic end_of_test();
      if (n_mismatch == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   // =====================================================================
   // core requests, pin stimulus and per-cycle checks
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      prev_phi1 <= phi1_out;
      prev_phi2 <= phi2_out;
      prev_irqn <= irqn_in;
      prev_rst <= rstn_in;
      if (cycles > 8000) begin
         n_mismatch++;
         end_of_test();
      end
      // first edge still sees the sequencer before reset has loaded it
      if (cycles > 0) chk(16'(phi1_out & phi2_out), 16'h0000, "phase overlap");
      if (rstn_in && prev_rst) chk(16'(irq_out), 16'(!prev_irqn), "irq");
      if (phi2_out && !prev_phi2) begin
         chk(addr_out, cur.addr, "addr");
         chk(16'(rw_out), 16'(!cur.write), "rw");
         chk(16'(sync_out), 16'(cur.fetch & !cur.write), "sync");
         chk(16'(data_oen_out), 16'(!(cur.write && gate)), "oen");
         if (cur.write && gate) chk(16'(data_out), 16'(cur.wdata), "wdata");
      end
      if (rd_valid_out) chk(16'(rd_data_out), 16'(exp_rd(cur.addr)), "rdata");
      if (!phi2_out && prev_phi2) begin
         chk(16'(rd_valid_out), 16'(!cur.write && rdy_in), "rvalid");
         if (!cur.write && !rdy_in) stalls <= stalls + 1;
      end
      if (req_take_out) begin
         if (takes > 0) begin
            chk(16'(cycles - last_take), 16'(BUS_CYC * (1 + stalls)), "take gap");
         end
         last_take <= cycles;
         stalls <= 0;
         g = 1'($urandom % 5 != 0);
         cur <= req_in;
         gate <= g;
         if (req_in.write && g) expm[req_in.addr] = req_in.wdata;
         req_in <= rnd_req();
         takes <= takes + 1;
      end
      // stall decision made fresh at each phase one start
      if (phi1_out && !prev_phi1) rdy_in <= 1'($urandom % 4 != 0);
      // each source holds its request until the core has seen it
      for (int i = 0; i < 2; i++) begin
         if (!irq_src[i] && $urandom % 32 == 0) irq_src[i] <= 1'b1;
         else if (irq_src[i] && irq_out && $urandom % 4 == 0) irq_src[i] <= 1'b0;
      end
      irqn_in <= !(|irq_src);
   end

   initial begin
      void'($urandom(6));
      req_in = rnd_req();
      repeat (12) @(posedge clk_in);
      chk(16'({phi1_out, phi2_out, rw_out, data_oen_out}), 16'h0003, "reset phases");
      chk(addr_out, ADDR_RST, "reset addr");
      chk(16'({sync_out, rd_valid_out, irq_out, nmi_pend_out}), 16'h0000, "reset flags");
      rstn_in <= 1'b1;
      while (takes < 40) @(posedge clk_in);
      nmin_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      #1 chk(16'(nmi_pend_out), 16'h0001, "nmi set");
      @(posedge clk_in);
      nmi_ack_in <= 1'b1;
      @(posedge clk_in);
      nmi_ack_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1 chk(16'(nmi_pend_out), 16'h0000, "nmi clear");
      @(posedge clk_in);
      nmin_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      // new edge in the same cycle as the clear: the edge must win
      nmin_in <= 1'b0;
      nmi_ack_in <= 1'b1;
      @(posedge clk_in);
      nmi_ack_in <= 1'b0;
      #1 chk(16'(nmi_pend_out), 16'h0001, "nmi over ack");
      @(posedge clk_in);
      nmin_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      end_of_test();
   end
endmodule : sbi_bus_if_tb

// ===== testbench/sbi_mem_model.sv
`timescale 1ns/1ns
// =====================================================================
// memory partner on the shared data path
module sbi_mem_model
   import sbi_pkg::*;
(
   input wire logic clk_in, // system clock
   input wire logic phi2_in, // second phase from the cpu
   input wire logic [ADDR_W-1:0] addr_in, // address lines
   input wire logic rw_in, // high read, low write
   input wire logic [DATA_W-1:0] wr_in, // byte driven by the cpu
   input wire logic oen_in, // cpu drive enable, low drives
   output logic [DATA_W-1:0] rd_out // byte this model drives
);
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];

   initial rd_out = 8'h00;

   always @(posedge clk_in) begin
      if (phi2_in && !rw_in && !oen_in) begin
         mem[addr_in] = wr_in;
      end
      if (phi2_in && rw_in) begin
         rd_out <= mem.exists(addr_in) ? mem[addr_in] : (addr_in[7:0] ^ addr_in[15:8]);
      end else begin
         // released bus must not keep showing the last byte
         rd_out <= ~rd_out;
      end
   end
endmodule : sbi_mem_model
